// ### logic/transceiver_channel_pll_reconfig.sv
`timescale 1ns/100ps
module transceiver_channel_pll_reconfig import reconfig_pkg::*; #(
  parameter int CHAN_AW = 2,
  parameter int IMG_DEPTH = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan_busy,
  output chan_cmd_t chan_cmd,
  output logic [CHAN_AW-1:0] chan_addr,
  output logic [WORD_AW-1:0] word_addr,
  output logic chan_done
);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, ISSUE, SETTLE, WAIT_DONE} state_t;

  bus_wr_t wr;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic busy_s;

  // Reads stay local, nothing is read from the channel
  axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Channel busy comes from another clock domain
  sync2 #(.W(1)) u_busy_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(chan_busy),
    .q(busy_s)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] img [IMG_DEPTH];
  cfg_t cfg;
  cfg_t next_cfg;
  cfg_t act;
  cfg_t next_act;
  state_t state;
  state_t next_state;
  logic [WORD_AW-1:0] last_idx;
  logic [WORD_AW-1:0] next_last_idx;
  logic [WORD_AW-1:0] next_word_addr;
  logic [1:0] settle;
  logic [1:0] next_settle;
  logic bulk;
  logic next_bulk;
  logic err;
  logic next_err;
  logic next_done;
  chan_cmd_t next_chan_cmd;
  logic [CHAN_AW-1:0] next_chan_addr;
  logic img_we;
  logic [WORD_AW-1:0] img_wa;
  logic start;
  logic start_all;
  logic [31:0] tmp;

  function automatic logic [WORD_AW-1:0] step(input logic [WORD_AW-1:0] a,
                                              input logic en);
    return en ? a + 6'h01 : a;
  endfunction

  function automatic logic in_image(input logic [11:0] a);
    return a[11:8] == IMG_PAGE;
  endfunction

  function automatic logic [WORD_AW-1:0] image_index(input logic [11:0] a);
    return a[WORD_AW+1:2];
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_act = act;
    next_state = state;
    next_last_idx = last_idx;
    next_word_addr = word_addr;
    next_settle = settle;
    next_bulk = bulk;
    next_err = err;
    next_done = chan_done;
    next_chan_cmd = chan_cmd;
    next_chan_cmd.wr = 1'b0;
    next_chan_addr = chan_addr;
    img_we = 1'b0;
    img_wa = word_addr;
    start = 1'b0;
    start_all = 1'b0;
    tmp = 32'h00000000;
    if (wr.we) begin
      case (wr.addr)
        OFF_CFG: begin
          tmp = apply_strb({8'h00, cfg}, wr.data, wr.strb);
          next_cfg = cfg_t'(tmp[23:0]); // R6
        end
        OFF_LAST: begin
          tmp = apply_strb({26'h0, last_idx}, wr.data, wr.strb);
          next_last_idx = tmp[WORD_AW-1:0];
        end
        // Control only acts while idle
        OFF_CTRL: begin
          if (wr.strb[0] && state == IDLE) begin
            if (wr.data[CTRL_ARST]) begin
              next_word_addr = '0; // R18
            end
            start = wr.data[CTRL_START] | wr.data[CTRL_ALL];
            start_all = wr.data[CTRL_ALL];
          end
        end
        OFF_DATA: begin
          if (state == IDLE) begin
            img_we = 1'b1;
            start = 1'b1;
          end
        end
        default: begin
          if (in_image(wr.addr) && state == IDLE) begin
            img_we = 1'b1;
            img_wa = image_index(wr.addr);
          end
        end
      endcase
    end
    if (start) begin
      // Illegal settings flag err and never run
      if (!cfg_ok(cfg)) begin
        next_err = 1'b1;
      end else begin
        next_err = 1'b0;
        next_done = 1'b0;
        next_act = cfg; // R19
        next_bulk = start_all;
        // Bulk always restarts from word zero
        if (start_all) begin
          next_word_addr = '0; // R7
        end
        next_state = ISSUE;
      end
    end
    case (state)
      IDLE: begin
      end
      ISSUE: begin
        // One pulse per image word
        next_chan_cmd.wr = 1'b1; // R1
        next_chan_cmd.word = img[word_addr];
        next_chan_cmd.mode = act.mode;
        next_chan_cmd.duplex = act.duplex;
        next_chan_cmd.pll_sel = act.pll_sel; // R8
        next_chan_cmd.pll_sel_en = act.pll_sel_en;
        next_chan_cmd.local_mux = act.pll_sel_en & ~act.outside; // R12
        next_chan_cmd.central_mux = act.pll_sel_en & act.outside;
        // Outside PLLs shift the logical address
        next_chan_addr = CHAN_AW'(act.chan + {4'h0, act.base}); // R15
        next_settle = SETTLE_CYC;
        next_state = SETTLE;
      end
      SETTLE: begin
        // Covers the two-stage busy synchroniser
        next_settle = settle - 2'h1;
        if (settle == 2'h1) begin
          next_state = WAIT_DONE;
        end
      end
      WAIT_DONE: begin
        // Synced busy low, channel has taken the word
        if (!busy_s) begin
          if (bulk && word_addr != last_idx) begin
            next_word_addr = step(word_addr, 1'b1); // R7
            next_state = ISSUE;
          end else begin
            next_word_addr = step(word_addr, bulk | act.addr_en); // R18
            next_done = 1'b1; // R17
            next_state = IDLE;
          end
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Image memory
  // ----------------------------------------------------------------
  // No reset, contents arrive over the bus
  always_ff @(posedge aclk) begin
    if (img_we) begin
      img[img_wa] <= wr.data[WORD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= cfg_t'(CFG_RESET);
      act <= cfg_t'(CFG_RESET);
      state <= IDLE;
      last_idx <= LAST_RESET;
      word_addr <= '0;
      settle <= 2'h0;
      bulk <= 1'b0;
      err <= 1'b0;
      chan_done <= 1'b0;
      chan_cmd <= '0;
      chan_addr <= '0;
    end else begin
      cfg <= next_cfg;
      act <= next_act;
      state <= next_state;
      last_idx <= next_last_idx;
      word_addr <= next_word_addr; // R5
      settle <= next_settle;
      bulk <= next_bulk;
      err <= next_err;
      chan_done <= next_done;
      chan_cmd <= next_chan_cmd;
      chan_addr <= next_chan_addr; // R2
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    // Unmapped offsets read back zero
    rd_data = 32'h00000000;
    case (rd_addr)
      OFF_CFG: rd_data = {8'h00, cfg};
      OFF_LAST: rd_data = {26'h0, last_idx};
      OFF_DATA: rd_data = {16'h0000, img[word_addr]};
      OFF_STATUS: begin
        rd_data[WORD_AW-1:0] = word_addr;
        rd_data[STAT_DONE] = chan_done;
        rd_data[STAT_BUSY] = (state != IDLE);
        rd_data[STAT_ERR] = err;
        rd_data[STAT_CHBUSY] = busy_s;
      end
      default: begin
        if (in_image(rd_addr)) begin
          rd_data = {16'h0000, img[image_index(rd_addr)]};
        end
      end
    endcase
  end

endmodule

// ### logic/reconfig_pkg.sv
// Behaviour
// R1: Only write transactions go toward the transceiver channel; no read path exists.
// R2: Channel address width follows channel count; two channels give two bits.
// R3: User logic drives channel address 01 to target the second channel.
// R4: User logic drives duplex select 00 for receive-and-transmit channels.
// R5: Done flag and six-bit word address output are always present.
// R6: Word-address reset, address enable, PLL select, enable, duplex are optional.
// R7: One bulk trigger writes every image word in succession. The code writes only words zero to last_idx, which resets to 7.
// R8: Transmit PLL select switches the channel among at most four PLLs.
// R9: PLL select with clock multiplier reconfig only for clock multiplier targets.
// R10: User reconfigures second clock multiplier first, then selects it.
// R11: PLL select is refused for four-lane or eight-lane bonded channels.
// R12: Switching within the block reprograms the local transmit clock multiplexer.
// R13: PLLs outside the transceiver block use reference index 2 or 3.
// R14: Clock multiplier PLLs inside the block use reference index 0 or 1.
// R15: Outside PLL addresses shift the channel numbers of later instances.
// R16: Mode select 100 activates clock multiplier PLL reconfiguration.
// R17: Done rises once the write-triggered reconfiguration has completed.
// R18: Word address advances per word; word-address reset returns it to zero.
// R19: Channel, duplex and mode are latched at start, changes ignored until done.
package reconfig_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CFG = 12'h004;
  localparam logic [11:0] OFF_DATA = 12'h008;
  localparam logic [11:0] OFF_LAST = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [3:0] IMG_PAGE = 4'h1;
  localparam int CTRL_START = 0;
  localparam int CTRL_ALL = 1;
  localparam int CTRL_ARST = 2;
  localparam int STAT_DONE = 8;
  localparam int STAT_BUSY = 9;
  localparam int STAT_ERR = 10;
  localparam int STAT_CHBUSY = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Values and timing
  // ----------------------------------------------------------------
  localparam int WORD_AW = 6;
  localparam int WORD_W = 16;
  localparam logic [2:0] MODE_CMU_PLL = 3'h4;
  localparam logic [1:0] DUPLEX_RXTX = 2'h0;
  localparam logic [1:0] IDX_INSIDE_MAX = 2'h1;
  localparam logic [1:0] IDX_OUTSIDE_MIN = 2'h2;
  localparam logic [WORD_AW-1:0] LAST_RESET = 6'h07;
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] base;
    logic bonded;
    logic aux_target;
    logic outside;
    logic addr_en;
    logic pll_sel_en;
    logic [1:0] pll_sel;
    logic [2:0] mode;
    logic [1:0] duplex;
    logic [7:0] chan;
  } cfg_t;

  localparam logic [23:0] CFG_RESET = 24'h010000;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } bus_wr_t;

  typedef struct packed {
    logic wr;
    logic [WORD_W-1:0] word;
    logic [2:0] mode;
    logic [1:0] duplex;
    logic [1:0] pll_sel;
    logic pll_sel_en;
    logic local_mux;
    logic central_mux;
  } chan_cmd_t;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    return (a[11:8] == IMG_PAGE) || (a == OFF_CTRL) || (a == OFF_CFG) ||
           (a == OFF_DATA) || (a == OFF_LAST) || (a == OFF_STATUS);
  endfunction

  function automatic logic cfg_ok(input cfg_t c);
    logic ok;
    ok = 1'b1;
    if (c.pll_sel_en && c.mode == MODE_CMU_PLL && c.aux_target) begin
      ok = 1'b0; // R9
    end
    if (c.pll_sel_en && c.bonded) begin
      ok = 1'b0; // R11
    end
    if (c.pll_sel_en && c.outside && c.pll_sel < IDX_OUTSIDE_MIN) begin
      ok = 1'b0; // R13
    end
    if (c.pll_sel_en && !c.outside && c.pll_sel > IDX_INSIDE_MAX) begin
      ok = 1'b0; // R14
    end
    return ok;
  endfunction

endpackage

// ### logic/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ### logic/axil_slave.sv
`timescale 1ns/100ps
module axil_slave import reconfig_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output bus_wr_t wr,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data
);

  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_rpend;
  logic rpend;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [11:0] next_rd_addr;
  bus_wr_t next_wr;

  always_comb begin
    next_awready = awready;
    next_wready = wready;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_rpend = rpend;
    next_rd_addr = rd_addr;
    next_wr = wr;
    next_wr.we = 1'b0;
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_wr.addr = {awaddr[11:2], 2'h0};
    end
    if (wvalid && wready) begin
      next_wready = 1'b0;
      next_wr.data = wdata;
      next_wr.strb = wstrb;
    end
    if (!awready && !wready && !bvalid) begin
      next_wr.we = addr_ok(wr.addr);
      next_bvalid = 1'b1;
      next_bresp = addr_ok(wr.addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rd_addr = {araddr[11:2], 2'h0};
      next_rpend = 1'b1;
    end
    if (rpend) begin
      next_rpend = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = addr_ok(rd_addr) ? rd_data : 32'h00000000;
      next_rresp = addr_ok(rd_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      rpend <= 1'b0;
      rd_addr <= 12'h000;
      wr <= '0;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rpend <= next_rpend;
      rd_addr <= next_rd_addr;
      wr <= next_wr;
    end
  end

endmodule

// ### sim/chan_model.sv
`timescale 1ns/100ps
module chan_model import reconfig_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire chan_cmd_t chan_cmd,
  output logic chan_busy
);
  // ----------------------------------------------------------------
  // Busy answer to each written word
  // ----------------------------------------------------------------
  logic [4:0] hold;

  // Busy rises the cycle after a word, slow mode stretches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold <= 5'h00;
    end else if (chan_cmd.wr) begin
      hold <= slow ? 5'h14 : 5'h01;
    end else if (hold != 5'h00) begin
      hold <= hold - 5'h01;
    end
  end

  assign chan_busy = (hold != 5'h00);
endmodule

// ### sim/reconfig_asserts.sv
`timescale 1ns/100ps
module reconfig_asserts import reconfig_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic chan_busy,
  input wire chan_cmd_t chan_cmd,
  input wire logic [WORD_AW-1:0] word_addr,
  input wire logic chan_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence word_gap;
    !chan_cmd.wr [*4];
  endsequence

  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rd_take |-> ##2 s_axi_rvalid)
    else $error("read response missing");
  word_spacing_a: assert property (chan_cmd.wr |=> word_gap)
    else $error("image words too close");
  done_clear_a: assert property (chan_cmd.wr |-> !chan_done)
    else $error("done high while writing");
  done_rise_a: assert property ($rose(chan_done) |-> !$past(chan_busy))
    else $error("done before channel idle");
  word_step_a: assert property ($changed(word_addr) |->
    (word_addr == $past(word_addr) + 6'h01) || (word_addr == 6'h00))
    else $error("word address jumped");
  mux_pick_a: assert property (chan_cmd.wr && chan_cmd.pll_sel_en |->
    chan_cmd.local_mux != chan_cmd.central_mux)
    else $error("clock mux choice wrong");
  out_index_a: assert property (chan_cmd.wr && chan_cmd.central_mux |->
    chan_cmd.pll_sel >= IDX_OUTSIDE_MIN)
    else $error("outside index too low");
  in_index_a: assert property (chan_cmd.wr && chan_cmd.local_mux |->
    chan_cmd.pll_sel <= IDX_INSIDE_MAX)
    else $error("inside index too high");
  held_fields_a: assert property (!chan_cmd.wr |-> $stable(chan_cmd.mode) &&
    $stable(chan_cmd.duplex) && $stable(chan_cmd.pll_sel))
    else $error("command fields moved");
endmodule

bind transceiver_channel_pll_reconfig reconfig_asserts i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .chan_busy,
  .chan_cmd, .word_addr, .chan_done
);

// ### sim/transceiver_channel_pll_reconfig_tb.sv
`timescale 1ns/100ps
module transceiver_channel_pll_reconfig_tb import reconfig_pkg::*;;
  logic aclk, aresetn, slow, chan_busy, chan_done;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, chan_addr;
  logic [WORD_AW-1:0] word_addr;
  logic [8:0] row;
  logic [8:0] rows [7] = '{9'h001, 9'h102, 9'h083, 9'h181, 9'h120, 9'h1D2, 9'h0C2};
  chan_cmd_t chan_cmd, last_cmd;
  cfg_t c;
  int bad_count, num_checks, cycles, n_wr, k;

  transceiver_channel_pll_reconfig i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_busy, .chan_cmd, .chan_addr,
    .word_addr, .chan_done
  );
  chan_model i_chan (.aclk, .aresetn, .slow, .chan_cmd, .chan_busy);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (chan_cmd.wr === 1'b1) begin
      n_wr++;
      last_cmd = chan_cmd;
    end
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask

  task automatic axr(input logic [11:0] a, input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, e);
  endtask

  task automatic wait_wr(input int t);
    while (!(chan_done === 1'b1 && n_wr == t)) @(posedge aclk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk(chan_done, 1'b0);
    chk(word_addr, 6'h00);
    axr(OFF_STATUS, RESP_OKAY);
    chk(rv, 32'h0);
    axr(OFF_CFG, RESP_OKAY);
    chk(rv, {8'h00, CFG_RESET});
    axr(OFF_LAST, RESP_OKAY);
    chk(rv, {26'h0, LAST_RESET});
    axr(12'h020, RESP_SLVERR);
    chk(n_wr, 0);
    $display("reset test done");
    c = CFG_RESET;
    c.chan = 8'h01;
    c.duplex = DUPLEX_RXTX;
    c.mode = MODE_CMU_PLL;
    axw(OFF_CFG, {8'h00, c}, RESP_OKAY);
    axw(OFF_DATA, 32'h0000A5C3, RESP_OKAY);
    wait_wr(1);
    chk(chan_addr, 2'b01);
    chk(last_cmd.word, 16'hA5C3);
    chk(last_cmd.mode, MODE_CMU_PLL);
    chk(last_cmd.duplex, DUPLEX_RXTX);
    chk(word_addr, 6'h01);
    $display("single word test done");
    for (int i = 0; i < 8; i++) axw(12'h100 + 12'(i * 4), 32'h1000 + i, RESP_OKAY);
    slow <= 1'b1;
    axw(OFF_CTRL, 32'h2, RESP_OKAY);
    c.mode = 3'h0;
    axw(OFF_CFG, {8'h00, c}, RESP_OKAY);
    axw(OFF_DATA, 32'h0000FFFF, RESP_OKAY);
    axr(OFF_STATUS, RESP_OKAY);
    chk(rv[STAT_BUSY], 1'b1);
    wait_wr(9);
    chk(n_wr, 9);
    chk(last_cmd.word, 16'h1007);
    chk(last_cmd.mode, MODE_CMU_PLL);
    chk(word_addr, 6'h08);
    axw(OFF_CTRL, 32'h4, RESP_OKAY);
    @(posedge aclk);
    chk(word_addr, 6'h00);
    slow <= 1'b0;
    $display("bulk test done");
    k = 9;
    // Clock multiplier already reconfigured, now switch sources
    for (int i = 0; i < 7; i++) begin
      row = rows[i];
      c = CFG_RESET;
      c.chan = 8'h01;
      c.pll_sel_en = 1'b1;
      {c.outside, c.aux_target, c.bonded, c.mode, c.pll_sel} = row[7:0];
      c.base = {3'h0, row[7]};
      axw(OFF_CFG, {8'h00, c}, RESP_OKAY);
      axw(OFF_DATA, 32'h00000100 + i, RESP_OKAY);
      if (row[8]) begin
        axr(OFF_STATUS, RESP_OKAY);
        chk(rv[STAT_ERR], 1'b1);
        chk(n_wr, k);
      end else begin
        k++;
        wait_wr(k);
        chk(last_cmd.pll_sel, row[1:0]);
        chk(last_cmd.pll_sel_en, 1'b1);
        chk(last_cmd.central_mux, row[7]);
        chk(last_cmd.local_mux, !row[7]);
        chk(chan_addr, {row[7], !row[7]});
      end
    end
    $display("pll select test done");
    conclude();
  end
endmodule
